//--- hw/spc_config_regs.sv
// Persistence, wait, pulse, analog control and revision register bank.
// Assumes a byte-wide register port decoded by the serial slave, and
// measurement engines that report samples as one-cycle pulses.
`default_nettype none
`include "spc_defs.svh"
module spc_config_regs #(
  parameter logic [2:0] DIE_REV = 3'h1, // Arbitrary value.
  parameter int WAIT_STEP_CYC = `SPC_WAIT_STEP_CYC
) (
  // Clock, reset, enable.
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // Register port.
  input wire spc_pkg::spc_wr_t wr_i,
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // Enables, thresholds and interrupt clears from neighbouring registers.
  input wire logic clear_irq_enable_i,
  input wire logic prox_irq_enable_i,
  input wire logic [15:0] clear_low_limit_i,
  input wire logic [15:0] clear_high_limit_i,
  input wire logic [15:0] prox_low_limit_i,
  input wire logic [15:0] prox_high_limit_i,
  input wire logic clear_irq_clr_i,
  input wire logic prox_irq_clr_i,
  // Measurement engines.
  input wire spc_pkg::spc_sample_t clear_sample_i,
  input wire spc_pkg::spc_sample_t prox_sample_i,
  input wire logic prox_saturated_i,
  input wire logic [15:0] prox_dark_i,
  input wire logic prox_start_i,
  input wire logic wait_start_i,
  input wire logic [7:0] wait_cycles_i,
  // Outputs to analog and host.
  output logic emitter_pulse_o,
  output logic prox_busy_o,
  output logic [7:0] emitter_current_o,
  output logic [6:0] colour_gain_o,
  output logic [15:0] prox_count_o,
  output logic wait_done_o,
  output logic clear_irq_o,
  output logic prox_irq_o,
  output logic int_o
);
  logic [7:0] persist_reg, waitcfg_reg, pulse_reg, control_reg;
  logic [5:0] clear_need, prox_need;
  logic clear_hit, prox_hit, pers_wr;
  logic [7:0] pulses_left_reg;
  spc_pkg::spc_pulse_st_t pst_reg;
  logic [31:0] step_cnt_reg;
  logic [11:0] wait_left_reg;
  logic wait_run_reg;

  initial begin
    if (WAIT_STEP_CYC < 1) $error("spc_config_regs: bad wait step");
  end

  // Clear persistence code to sample count.
  function automatic logic [5:0] clear_need_f(input logic [3:0] code);
    if (code < 4'h4) clear_need_f = {2'h0, code};
    else clear_need_f = 6'((code - 4'h3) * 5);
  endfunction

  // Drive code halves full current per step, gain code to multiplier.
  function automatic logic [7:0] drive_f(input logic [1:0] code);
    drive_f = 8'h80 >> code;
  endfunction
  function automatic logic [6:0] gain_f(input logic [1:0] code);
    case (code)
      2'h0: gain_f = 7'h01;
      2'h1: gain_f = 7'h04;
      2'h2: gain_f = 7'h10;
      default: gain_f = 7'h3C;
    endcase
  endfunction

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      persist_reg <= `SPC_RST_VAL;
      waitcfg_reg <= `SPC_RST_VAL;
      pulse_reg <= `SPC_RST_VAL;
      control_reg <= `SPC_RST_VAL;
    end else if (clk_en_i && wr_i.wr) begin
      // Reserved bits are stored as written; the host keeps them legal.
      case (wr_i.addr)
        `SPC_ADDR_PERSIST: persist_reg <= wr_i.data;
        `SPC_ADDR_WAITCFG: waitcfg_reg <= wr_i.data;
        `SPC_ADDR_PULSE: pulse_reg <= wr_i.data;
        `SPC_ADDR_CONTROL: control_reg <= wr_i.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o <= 8'h00;
    end else if (clk_en_i) begin
      case (rd_addr_i)
        `SPC_ADDR_PERSIST: rd_data_o <= persist_reg;
        `SPC_ADDR_WAITCFG: rd_data_o <= waitcfg_reg;
        `SPC_ADDR_PULSE: rd_data_o <= pulse_reg;
        `SPC_ADDR_CONTROL: rd_data_o <= control_reg;
        `SPC_ADDR_REV: rd_data_o <= {5'h00, DIE_REV};
        default: rd_data_o <= 8'h00;
      endcase
    end
  end

  assign pers_wr = clk_en_i && wr_i.wr && (wr_i.addr == `SPC_ADDR_PERSIST);
  assign clear_need = clear_need_f(persist_reg[`SPC_CLEAR_PERSIST_CODE_MSB:`SPC_CLEAR_PERSIST_CODE_LSB]);
  assign prox_need = {2'h0, persist_reg[`SPC_PROX_PERSIST_CODE_MSB:`SPC_PROX_PERSIST_CODE_LSB]};

  // clear-channel filter, zero code fires on every sample.
  spc_persist #(.CW(6)) u_clear (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .clk_en_i(clk_en_i),
    .need_i(clear_need),
    .restart_i(pers_wr),
    .low_i(clear_low_limit_i),
    .high_i(clear_high_limit_i),
    .sample_i(clear_sample_i),
    .hit_o(clear_hit)
  );

  // proximity filter, zero code fires on every sample.
  spc_persist #(.CW(6)) u_prox (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .clk_en_i(clk_en_i),
    .need_i(prox_need),
    .restart_i(pers_wr),
    .low_i(prox_low_limit_i),
    .high_i(prox_high_limit_i),
    .sample_i(prox_sample_i),
    .hit_o(prox_hit)
  );

  // set wins over clear, so no event is lost.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clear_irq_o <= 1'b0;
    end else if (clk_en_i) begin
      if (clear_hit && clear_irq_enable_i) clear_irq_o <= 1'b1;
      else if (clear_irq_clr_i) clear_irq_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prox_irq_o <= 1'b0;
    end else if (clk_en_i) begin
      if (prox_hit && prox_irq_enable_i) prox_irq_o <= 1'b1;
      else if (prox_irq_clr_i) prox_irq_o <= 1'b0;
    end
  end

  // The shared pin is an OR of the two flags.
  assign int_o = clear_irq_o || prox_irq_o;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      emitter_current_o <= 8'h80;
      colour_gain_o <= 7'h01;
    end else if (clk_en_i) begin
      emitter_current_o <= drive_f(control_reg[`SPC_DRIVE_MSB:`SPC_DRIVE_LSB]);
      colour_gain_o <= gain_f(control_reg[`SPC_GAIN_MSB:`SPC_GAIN_LSB]);
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prox_count_o <= 16'h0000;
    end else if (clk_en_i && prox_sample_i.done) begin
      if (control_reg[`SPC_PROX_SATURATION_MODE_BIT] && prox_saturated_i) prox_count_o <= prox_dark_i;
      else prox_count_o <= prox_sample_i.value;
    end
  end

  // exact pulse count; a pulse is one high cycle then one low cycle.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pst_reg <= spc_pkg::SPC_P_IDLE;
      pulses_left_reg <= 8'h00;
    end else if (clk_en_i) begin
      case (pst_reg)
        spc_pkg::SPC_P_IDLE: begin
          if (prox_start_i && pulse_reg != 8'h00) begin
            pulses_left_reg <= pulse_reg - 8'h01;
            pst_reg <= spc_pkg::SPC_P_HIGH;
          end
        end
        spc_pkg::SPC_P_HIGH: pst_reg <= spc_pkg::SPC_P_LOW;
        spc_pkg::SPC_P_LOW: begin
          if (pulses_left_reg == 8'h00) begin
            pst_reg <= spc_pkg::SPC_P_IDLE;
          end else begin
            pulses_left_reg <= pulses_left_reg - 8'h01;
            pst_reg <= spc_pkg::SPC_P_HIGH;
          end
        end
        default: pst_reg <= spc_pkg::SPC_P_IDLE;
      endcase
    end
  end
  assign emitter_pulse_o = (pst_reg == spc_pkg::SPC_P_HIGH);
  assign prox_busy_o = (pst_reg != spc_pkg::SPC_P_IDLE);

  // step length in cycles
  // Wait code is two's complement: 0xFF is one step, 0x00 is 256.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_run_reg <= 1'b0;
      wait_left_reg <= 12'h000;
      step_cnt_reg <= 32'h0;
      wait_done_o <= 1'b0;
    end else if (clk_en_i) begin
      wait_done_o <= 1'b0;
      if (!wait_run_reg) begin
        if (wait_start_i) begin
          wait_run_reg <= 1'b1;
          step_cnt_reg <= 32'h0;
          wait_left_reg <= waitcfg_reg[`SPC_WAIT_STRETCH_BIT]
            ? 12'((9'h100 - {1'b0, wait_cycles_i}) * `SPC_STRETCH_FACTOR)
            : 12'(9'h100 - {1'b0, wait_cycles_i});
        end
      end else if (step_cnt_reg == 32'(WAIT_STEP_CYC - 1)) begin
        step_cnt_reg <= 32'h0;
        if (wait_left_reg == 12'h001) begin
          wait_run_reg <= 1'b0;
          wait_done_o <= 1'b1;
        end
        wait_left_reg <= wait_left_reg - 12'h001;
      end else begin
        step_cnt_reg <= step_cnt_reg + 32'h1;
      end
    end
  end

  // Assertions.
  property p_rev_ro;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (clk_en_i && rd_addr_i == `SPC_ADDR_REV) |=> rd_data_o == {5'h00, DIE_REV};
  endproperty
  a_rev_ro: assert property (p_rev_ro) else $error("revision read wrong");
  property p_clear_every;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (clk_en_i && clear_sample_i.done && persist_reg[3:0] == 4'h0 && clear_irq_enable_i)
        |=> clear_irq_o;
  endproperty
  a_clear_every: assert property (p_clear_every) else $error("clear zero code missed");
  property p_prox_every;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (clk_en_i && prox_sample_i.done && persist_reg[7:4] == 4'h0 && prox_irq_enable_i)
        |=> prox_irq_o;
  endproperty
  a_prox_every: assert property (p_prox_every) else $error("prox zero code missed");
  property p_clear_gate;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (!clear_irq_o && !clear_irq_enable_i) |=> !clear_irq_o;
  endproperty
  a_clear_gate: assert property (p_clear_gate) else $error("clear flag without enable");
  property p_prox_gate;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (!prox_irq_o && (!prox_hit || !prox_irq_enable_i)) |=> !prox_irq_o;
  endproperty
  a_prox_gate: assert property (p_prox_gate) else $error("prox flag without enabled hit");
  property p_sticky;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (prox_irq_o && !prox_irq_clr_i) |=> prox_irq_o;
  endproperty
  a_sticky: assert property (p_sticky) else $error("prox flag dropped");
  property p_need60;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      persist_reg[3:0] == 4'hF |-> clear_need == 6'd60;
  endproperty
  a_need60: assert property (p_need60) else $error("clear code map wrong");
  property p_pulse_gap;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (clk_en_i && emitter_pulse_o) |=> !emitter_pulse_o;
  endproperty
  a_pulse_gap: assert property (p_pulse_gap) else $error("pulse too long");
  property p_sat;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (clk_en_i && prox_sample_i.done && control_reg[4] && prox_saturated_i)
        |=> prox_count_o == $past(prox_dark_i);
  endproperty
  a_sat: assert property (p_sat) else $error("dark value not used");
  c_clear_irq: cover property (@(posedge ref_clk_i) $rose(clear_irq_o));
  c_prox_irq: cover property (@(posedge ref_clk_i) $rose(prox_irq_o));
  c_wait_done: cover property (@(posedge ref_clk_i) wait_done_o);
endmodule // spc_config_regs
`default_nettype wire

//--- include/spc_defs.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes inclusion by bare name from the design files.
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH
`define SPC_ADDR_PERSIST 8'h0C
`define SPC_ADDR_WAITCFG 8'h0D
`define SPC_ADDR_PULSE 8'h0E
`define SPC_ADDR_CONTROL 8'h0F
`define SPC_ADDR_REV 8'h11
`define SPC_RST_VAL 8'h00
`define SPC_PROX_PERSIST_CODE_MSB 7
`define SPC_PROX_PERSIST_CODE_LSB 4
`define SPC_CLEAR_PERSIST_CODE_MSB 3
`define SPC_CLEAR_PERSIST_CODE_LSB 0
`define SPC_WAIT_STRETCH_BIT 1
`define SPC_DRIVE_MSB 7
`define SPC_DRIVE_LSB 6
`define SPC_PROX_SATURATION_MODE_BIT 4
`define SPC_GAIN_MSB 1
`define SPC_GAIN_LSB 0
`define SPC_STRETCH_FACTOR 12
`define SPC_WAIT_STEP_NS 2380000
`define SPC_CLK_PERIOD_NS 5
`define SPC_WAIT_STEP_CYC (`SPC_WAIT_STEP_NS / `SPC_CLK_PERIOD_NS)
`endif

//--- include/spc_pkg.sv
// Types shared by the configuration bank and its persistence filter.
// Assumes nothing of the defs header, which it does not include.
`default_nettype none
package spc_pkg;
  // Register write request from the serial slave.
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } spc_wr_t;
  // One finished measurement of a channel.
  typedef struct packed {
    logic        done;
    logic [15:0] value;
  } spc_sample_t;
  // Pulse engine state.
  typedef enum logic [1:0] {
    SPC_P_IDLE = 2'b00,
    SPC_P_HIGH = 2'b01,
    SPC_P_LOW  = 2'b10
  } spc_pulse_st_t;
endpackage
`default_nettype wire

//--- hw/spc_persist.sv
// Consecutive out-of-range persistence filter for one channel.
// Assumes samples arrive as one-cycle pulses on the same clock.
`default_nettype none
`include "spc_defs.svh"
module spc_persist #(
  parameter int CW = 6
) (
  // Clock, reset, enable.
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // Settings.
  input wire logic [5:0] need_i,
  input wire logic restart_i,
  input wire logic [15:0] low_i,
  input wire logic [15:0] high_i,
  // Sample and result.
  input wire spc_pkg::spc_sample_t sample_i,
  output logic hit_o
);
  logic [CW-1:0] run_reg;
  logic out_rng;
  initial begin
    if (CW < 6) $error("spc_persist: counter too narrow");
  end
  assign out_rng = (sample_i.value < low_i) || (sample_i.value > high_i);
  // Zero need fires on every sample; else count consecutive out-of-range samples.
  assign hit_o = sample_i.done && ((need_i == 6'h00) ||
                 (out_rng && ({1'b0, CW'(need_i)} <= {1'b0, run_reg} + (CW+1)'(1))));
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_reg <= '0;
    end else if (clk_en_i) begin
      if (restart_i) begin
        run_reg <= '0;
      end else if (sample_i.done) begin
        if (!out_rng) run_reg <= '0;
        else if (run_reg != {CW{1'b1}}) run_reg <= run_reg + CW'(1);
      end
    end
  end
endmodule // spc_persist
`default_nettype wire

//--- test/spc_host_model.sv
// Host-side register writer standing in for the serial host.
// Assumes the bench raises a request for one cycle on the shared clock.
`default_nettype none
module spc_host_model (
  // Clock.
  input wire logic ref_clk_i,
  // Request from the bench.
  input wire logic go_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] data_i,
  // Write port toward the bank.
  output var spc_pkg::spc_wr_t wr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] safe;
  // reserved bits cleared
  // A careful host never sets reserved bits and always keeps control bit 5 high.
  always_comb begin
    safe = data_i;
    if (addr_i == 8'h0D) safe = data_i & 8'h02;
    if (addr_i == 8'h0F) safe = (data_i & 8'hF3) | 8'h20;
  end
  // The write is presented one cycle after the request and held for one cycle.
  always_ff @(posedge ref_clk_i) wr_o <= '{wr: go_i, addr: addr_i, data: safe};
endmodule // spc_host_model
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the configuration bank and its persistence filters.
// Assumes the package, the bank and the host model are compiled first.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WSC = 4;
  localparam logic [2:0] DIE_REV_FIELD = 3'h5; // Arbitrary value.
  localparam logic [15:0] LO = 16'h0064;
  localparam logic [15:0] HI = 16'h00C8;
  localparam logic [6:0] GT [4] = '{7'h01, 7'h04, 7'h10, 7'h3C};
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic go = 1'b0;
  logic [7:0] wa = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] ra = 8'h00;
  logic cen = 1'b1;
  logic pen = 1'b1;
  logic ccl = 1'b0;
  logic pcl = 1'b0;
  logic prox_saturation_mode = 1'b0;
  logic pst = 1'b0;
  logic wst = 1'b0;
  logic [7:0] wcy = 8'hFF;
  spc_pkg::spc_sample_t cs = '0;
  spc_pkg::spc_sample_t ps = '0;
  spc_pkg::spc_wr_t wr;
  logic [7:0] rd;
  logic [7:0] cur;
  logic [6:0] gain;
  logic [15:0] pcnt;
  logic epo, busy, wdone, cirq, pirq, int_w;
  int num_errors = 0;
  int samples_checked = 0;

  // Free-running 200 MHz clock.
  always #2.5 ref_clk_i = ~ref_clk_i;

  spc_host_model u_spc_host_model (.ref_clk_i(ref_clk_i), .go_i(go), .addr_i(wa),
    .data_i(wd), .wr_o(wr));
  spc_config_regs #(.DIE_REV(DIE_REV_FIELD), .WAIT_STEP_CYC(WSC)) u_spc_config_regs (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .wr_i(wr),
    .rd_addr_i(ra), .rd_data_o(rd), .clear_irq_enable_i(cen), .prox_irq_enable_i(pen),
    .clear_low_limit_i(LO), .clear_high_limit_i(HI), .prox_low_limit_i(LO),
    .prox_high_limit_i(HI), .clear_irq_clr_i(ccl), .prox_irq_clr_i(pcl),
    .clear_sample_i(cs), .prox_sample_i(ps), .prox_saturated_i(prox_saturation_mode),
    .prox_dark_i(16'h0042), .prox_start_i(pst), .wait_start_i(wst), .wait_cycles_i(wcy),
    .emitter_pulse_o(epo), .prox_busy_o(busy), .emitter_current_o(cur),
    .colour_gain_o(gain), .prox_count_o(pcnt), .wait_done_o(wdone),
    .clear_irq_o(cirq), .prox_irq_o(pirq), .int_o(int_w));

  // Comparison shared by every scenario.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Let edges pass, then sample settled outputs.
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    go <= 1'b1;
    wa <= a;
    wd <= d;
    @(posedge ref_clk_i);
    go <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge ref_clk_i);
    ra <= a;
    tick(1);
    chk(16'(rd & m), 16'(exp));
  endtask

  // Value the bank should hold after the host has written it.
  function automatic logic [7:0] host_val(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h0D) return d & 8'h02;
    if (a == 8'h0F) return (d & 8'hF3) | 8'h20;
    return d;
  endfunction

  function automatic int need_clr(input logic [3:0] c);
    return (c < 4) ? int'(c) : (int'(c) - 3) * 5;
  endfunction

  function automatic logic [15:0] oor();
    if ($urandom_range(1) == 1) return 16'(int'(HI) + 1 + $urandom_range(999));
    return 16'($urandom_range(99));
  endfunction

  task automatic smp(input bit p, input logic [15:0] v, input logic sat);
    @(posedge ref_clk_i);
    if (p) ps <= '{done: 1'b1, value: v};
    else cs <= '{done: 1'b1, value: v};
    prox_saturation_mode <= sat;
    @(posedge ref_clk_i);
    ps <= '0;
    cs <= '0;
    prox_saturation_mode <= 1'b0;
  endtask

  // A broken run must restart the count, so the final sample completes a fresh run of n.
  task automatic persist(input bit p, input logic [3:0] c);
    int n;
    n = p ? int'(c) : need_clr(c);
    wr_reg(8'h0C, p ? {c, 4'h0} : {4'h0, c});
    if (n > 1) begin
      repeat (n - 1) smp(p, oor(), 1'b0);
      smp(p, 16'h0096, 1'b0);
    end
    if (n > 1) repeat (n - 1) smp(p, oor(), 1'b0);
    tick(2);
    if (n > 0) chk(16'(p ? pirq : cirq), 16'h0000);
    smp(p, (n == 0) ? 16'h0096 : oor(), 1'b0);
    tick(5);
    chk(16'(p ? pirq : cirq), 16'h0001);
    chk(16'(int_w), 16'h0001);
    @(posedge ref_clk_i);
    if (p) pcl <= 1'b1;
    else ccl <= 1'b1;
    @(posedge ref_clk_i);
    pcl <= 1'b0;
    ccl <= 1'b0;
    tick(2);
    chk(16'(p ? pirq : cirq), 16'h0000);
  endtask

  task automatic pulses(input logic [7:0] cnt);
    int k;
    int b;
    wr_reg(8'h0E, cnt);
    @(posedge ref_clk_i);
    pst <= 1'b1;
    @(posedge ref_clk_i);
    pst <= 1'b0;
    k = 0;
    b = 0;
    // Each pulse is one high and one low cycle, so busy lasts twice the count.
    repeat (600) begin
      #1;
      if (epo === 1'b1) k++;
      if (busy === 1'b1) b++;
      @(posedge ref_clk_i);
    end
    chk(16'(k), 16'(cnt));
    chk(16'(b), 16'(2 * int'(cnt)));
    chk(16'(busy), 16'h0000);
  endtask

  task automatic wait_run(input logic [7:0] code, input bit lng);
    int k;
    wr_reg(8'h0D, {6'h00, lng, 1'b0});
    @(posedge ref_clk_i);
    wcy <= code;
    wst <= 1'b1;
    @(posedge ref_clk_i);
    wst <= 1'b0;
    k = 0;
    do begin
      tick(1);
      k++;
    end while (wdone !== 1'b1 && k < 2000);
    chk(16'(k), 16'((256 - int'(code)) * WSC * (lng ? 12 : 1)));
  endtask

  task automatic test_done();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog sized well beyond the expected run length.
  initial begin
    #400000;
    num_errors++;
    test_done();
  end

  initial begin
    logic [7:0] a;
    logic [7:0] d;
    void'($urandom(32'hD29BE8E7));
    repeat (5) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    for (int i = 12; i < 16; i++) rd_chk(8'(i), 8'h00, 8'hFF);
    // A frozen bank must ignore a write and keep its reset value.
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    wr_reg(8'h0E, 8'hA5);
    @(posedge ref_clk_i);
    clk_en_i <= 1'b1;
    rd_chk(8'h0E, 8'h00, 8'hFF);
    rd_chk(8'h11, 8'(DIE_REV_FIELD), 8'h07);
    wr_reg(8'h11, 8'hFF);
    rd_chk(8'h11, 8'(DIE_REV_FIELD), 8'h07);
    rd_chk(8'h10, 8'h00, 8'hFF);
    repeat (20) begin
      a = 8'(12 + $urandom_range(3));
      d = 8'($urandom);
      wr_reg(a, d);
      rd_chk(a, host_val(a, d), 8'hFF);
    end
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h0F, {i[1:0], 4'h0, 2'(3 - i)});
      tick(2);
      chk(16'(cur), 16'(8'h80 >> i));
      chk(16'(gain), 16'(GT[3 - i]));
    end
    wr_reg(8'h0F, 8'h10);
    smp(1'b1, 16'h1234, 1'b1);
    tick(2);
    chk(pcnt, 16'h0042);
    smp(1'b1, 16'h1234, 1'b0);
    tick(2);
    chk(pcnt, 16'h1234);
    wr_reg(8'h0F, 8'h00);
    smp(1'b1, 16'h4321, 1'b1);
    tick(2);
    chk(pcnt, 16'h4321);
    @(posedge ref_clk_i);
    pen <= 1'b0;
    cen <= 1'b0;
    wr_reg(8'h0C, 8'h00);
    // Earlier out-of-range samples may have left the proximity flag set.
    @(posedge ref_clk_i);
    pcl <= 1'b1;
    @(posedge ref_clk_i);
    pcl <= 1'b0;
    smp(1'b1, 16'h0096, 1'b0);
    smp(1'b0, 16'h0096, 1'b0);
    tick(3);
    chk(16'(pirq), 16'h0000);
    chk(16'(cirq), 16'h0000);
    @(posedge ref_clk_i);
    pen <= 1'b1;
    cen <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      persist(1'b0, 4'(c));
      persist(1'b1, 4'(c));
    end
    pulses(8'h00);
    pulses(8'h01);
    pulses(8'hFF);
    pulses(8'(2 + $urandom_range(250)));
    wait_run(8'hFF, 1'b0);
    wait_run(8'hFE, 1'b1);
    wait_run(8'(8'hF0 + $urandom_range(15)), 1'($urandom_range(1)));
    test_done();
  end
endmodule // tb
`default_nettype wire
